// ===== rtl/bss_pkg.sv
package bss_pkg;

  // ----------------------------------------------------------------
  // register map (management addresses, never paged)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_BASIC_STATUS    = 5'h01;
  localparam logic [4:0] ADDR_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] ADDR_INTERRUPT_FLAGS = 5'h0C;

  // ----------------------------------------------------------------
  // basic_status field positions
  // ----------------------------------------------------------------
  localparam int BIT_CAP_FAST_FULL_DUPLEX    = 14;
  localparam int BIT_CAP_FAST_HALF_DUPLEX    = 13;
  localparam int BIT_CAP_TEN_FULL_DUPLEX     = 12;
  localparam int BIT_CAP_TEN_HALF_DUPLEX     = 11;
  localparam int BIT_EXTENDED_STATUS_PRESENT = 8;
  localparam int BIT_NO_PREAMBLE_CAPABLE     = 6;
  localparam int BIT_AUTONEG_DONE            = 5;
  localparam int BIT_REMOTE_FAULT_LATCH      = 4;
  localparam int BIT_AUTONEG_CAPABLE         = 3;
  localparam int BIT_LINK_UP_LATCH           = 2;
  localparam int BIT_EXTENDED_REGS_PRESENT   = 0;

  // interrupt_flags: mirrors low, enables high
  localparam int BIT_IRQ_FAULT_MIRROR = 4;
  localparam int BIT_IRQ_LINK_MIRROR  = 2;
  localparam int BIT_IRQ_FAULT_ENABLE = 12;
  localparam int BIT_IRQ_LINK_ENABLE  = 10;

  // remote fault field inside the partner ability word
  localparam int             PARTNER_FAULT_HI = 13;
  localparam int             PARTNER_FAULT_LO = 12;
  localparam logic [1:0]     PARTNER_NO_FAULT = 2'h0;
  localparam logic [15:0]    RESET_WORD       = 16'h0000;

  // ----------------------------------------------------------------
  // management frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [3:0] CNT_OP_LAST   = 4'h1;
  localparam logic [3:0] CNT_ADDR_LAST = 4'h4;
  localparam logic [3:0] CNT_DATA_LAST = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_OP,
    ST_PHY,
    ST_REG,
    ST_TA,
    ST_DATA
  } bss_mdio_state_type;

  // register access request from the serial engine
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } bss_req_type;

endpackage

// ===== rtl/bss_mdio_engine.sv
`timescale 1ns/1ps
module bss_mdio_engine #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               mdc_in,
  input  wire logic               mdio_in,
  input  wire logic [15:0]        rd_data,
  output bss_pkg::bss_req_type    req,
  output logic                    mdio_out,
  output logic                    mdio_oe
);

  // ----------------------------------------------------------------
  // pin synchronisers and clock edge detect
  // ----------------------------------------------------------------
  logic                        mdc_s1_q, mdc_s2_q, mdc_s3_q;
  logic                        mdio_s1_q, mdio_s2_q;
  bss_pkg::bss_mdio_state_type state_q;
  logic [3:0]                  cnt_q;
  logic [1:0]                  op_q;
  logic [4:0]                  phy_q;
  logic [4:0]                  reg_q;
  logic [15:0]                 shift_q;
  logic                        mine_q;
  bss_pkg::bss_req_type        req_q;
  logic                        out_q;
  logic                        oe_q;

  wire logic mdc_rise = mdc_s2_q & ~mdc_s3_q;
  wire logic bit_in   = mdio_s2_q;
  wire logic hit      = (phy_q == PHY_ADDR);
  wire logic rd_mine  = mine_q & (op_q == bss_pkg::OP_READ);
  wire logic wr_mine  = mine_q & (op_q == bss_pkg::OP_WRITE);

  // two flops before anything looks at the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      {mdc_s1_q, mdc_s2_q, mdc_s3_q} <= 3'h0;
      {mdio_s1_q, mdio_s2_q}         <= 2'h3;
    end else begin
      {mdc_s1_q, mdc_s2_q, mdc_s3_q} <= {mdc_in, mdc_s1_q, mdc_s2_q};
      {mdio_s1_q, mdio_s2_q}         <= {mdio_in, mdio_s1_q};
    end
  end

  // ----------------------------------------------------------------
  // frame walker: start, opcode, addresses, turnaround, data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= bss_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      op_q    <= 2'h0;
      phy_q   <= 5'h00;
      reg_q   <= 5'h00;
      shift_q <= 16'h0000;
      mine_q  <= 1'b0;
      req_q   <= '0;
      out_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      req_q.rd <= 1'b0;
      req_q.wr <= 1'b0;
      if (req_q.rd) begin
        shift_q <= rd_data;               // snapshot taken with the read
      end
      if (mdc_rise) begin
        unique case (state_q)
          // no preamble needed: a zero then a one opens the frame
          bss_pkg::ST_IDLE: begin
            if (!bit_in) state_q <= bss_pkg::ST_START;
          end
          bss_pkg::ST_START: begin
            cnt_q <= 4'h0;
            if (bit_in) state_q <= bss_pkg::ST_OP;
          end
          bss_pkg::ST_OP: begin
            op_q  <= {op_q[0], bit_in};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == bss_pkg::CNT_OP_LAST) begin
              cnt_q   <= 4'h0;
              state_q <= bss_pkg::ST_PHY;
            end
          end
          bss_pkg::ST_PHY: begin
            phy_q <= {phy_q[3:0], bit_in};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == bss_pkg::CNT_ADDR_LAST) begin
              cnt_q   <= 4'h0;
              state_q <= bss_pkg::ST_REG;
            end
          end
          bss_pkg::ST_REG: begin
            reg_q <= {reg_q[3:0], bit_in};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == bss_pkg::CNT_ADDR_LAST) begin
              cnt_q      <= 4'h0;
              state_q    <= bss_pkg::ST_TA;
              mine_q     <= hit;
              req_q.addr <= {reg_q[3:0], bit_in};
              req_q.rd   <= hit & (op_q == bss_pkg::OP_READ);
            end
          end
          // second turnaround bit driven low on a read
          bss_pkg::ST_TA: begin
            if (cnt_q == 4'h0) begin
              cnt_q <= 4'h1;
              oe_q  <= rd_mine;
              out_q <= 1'b0;
            end else begin
              cnt_q   <= 4'h0;
              state_q <= bss_pkg::ST_DATA;
              out_q   <= shift_q[15];
              shift_q <= {shift_q[14:0], 1'b0};
            end
          end
          bss_pkg::ST_DATA: begin
            cnt_q <= cnt_q + 4'h1;
            if (rd_mine) begin
              out_q   <= shift_q[15];
              shift_q <= {shift_q[14:0], 1'b0};
            end else begin
              shift_q <= {shift_q[14:0], bit_in};
            end
            if (cnt_q == bss_pkg::CNT_DATA_LAST) begin
              state_q     <= bss_pkg::ST_IDLE;
              oe_q        <= 1'b0;
              req_q.wr    <= wr_mine;
              req_q.wdata <= {shift_q[14:0], bit_in};
            end
          end
        endcase
      end
    end
  end

  assign req      = req_q;
  assign mdio_out = out_q;
  assign mdio_oe  = oe_q;

endmodule

// ===== rtl/bss_status_top.sv
`timescale 1ns/1ps
module bss_status_top #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic        rx_loss_of_signal_in,
  input  wire logic        cdr_loss_of_lock,
  input  wire logic        sgmii_mode,
  input  wire logic        autoneg_done_in,
  input  wire logic        pcs_link_up,
  input  wire logic [15:0] partner_word,
  input  wire logic        partner_word_valid,
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  bss_pkg::bss_req_type req;
  logic                 los_s1_q, los_s2_q;
  logic                 autoneg_done_q;
  logic                 remote_fault_latch_q;
  logic                 remote_fault_latch_d;
  logic                 link_up_latch_q;
  logic                 link_up_latch_d;
  logic [15:0]          partner_ability_q;
  logic                 fault_irq_en_q;
  logic                 link_irq_en_q;
  logic                 irq_q;
  logic [15:0]          basic_status;
  logic [15:0]          interrupt_flags;
  logic [15:0]          rd_data;

  // ----------------------------------------------------------------
  // management serial engine
  // ----------------------------------------------------------------
  bss_mdio_engine #(
    .PHY_ADDR (PHY_ADDR)
  ) u_engine (
    .clk      (clk),
    .reset    (reset),
    .mdc_in   (mdc_in),
    .mdio_in  (mdio_in),
    .rd_data  (rd_data),
    .req      (req),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // full five-bit compare, no page term enters the decode
  // the read strobe lands in the cycle the engine takes its snapshot,
  // so the word shifted out shows the latches before their clear
  wire logic sel_status  = (req.addr == bss_pkg::ADDR_BASIC_STATUS);
  wire logic sel_partner = (req.addr == bss_pkg::ADDR_PARTNER_ABILITY);
  wire logic sel_irq     = (req.addr == bss_pkg::ADDR_INTERRUPT_FLAGS);
  wire logic read_status = req.rd & sel_status;
  wire logic write_irq   = req.wr & sel_irq;

  // ----------------------------------------------------------------
  // loss of signal pin synchroniser
  // ----------------------------------------------------------------
  // the pin is asynchronous, two flops before the fault logic
  always_ff @(posedge clk) begin
    if (reset) begin
      los_s1_q <= 1'b0;
      los_s2_q <= 1'b0;
    end else begin
      los_s1_q <= rx_loss_of_signal_in;
      los_s2_q <= los_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // partner ability word
  // ----------------------------------------------------------------
  // keeps the last configuration word seen from the partner
  always_ff @(posedge clk) begin
    if (reset) begin
      partner_ability_q <= bss_pkg::RESET_WORD;
    end else if (partner_word_valid) begin
      partner_ability_q <= partner_word;
    end
  end

  wire logic [1:0] partner_fault_field =
    partner_ability_q[bss_pkg::PARTNER_FAULT_HI:bss_pkg::PARTNER_FAULT_LO];

  // ----------------------------------------------------------------
  // fault condition per mode
  // ----------------------------------------------------------------
  // serial gigabit mode watches the receiver, fibre mode the partner
  // lock loss comes from logic on this clock, so it needs no synchroniser
  wire logic sgmii_fault = los_s2_q | cdr_loss_of_lock;
  wire logic fibre_fault =
    (partner_fault_field != bss_pkg::PARTNER_NO_FAULT);
  wire logic fault_now = sgmii_mode ? sgmii_fault : fibre_fault;

  // ----------------------------------------------------------------
  // latched indicators
  // ----------------------------------------------------------------
  // condition present holds the latch; a read only acts without it
  always_comb begin
    remote_fault_latch_d = remote_fault_latch_q;
    if (fault_now) begin
      remote_fault_latch_d = 1'b1;
    end else if (read_status) begin
      remote_fault_latch_d = 1'b0;
    end
  end

  // link down forces zero even in the cycle of a read
  always_comb begin
    link_up_latch_d = link_up_latch_q;
    if (!pcs_link_up) begin
      link_up_latch_d = 1'b0;
    end else if (read_status) begin
      link_up_latch_d = 1'b1;
    end
  end

  // indicators start at zero out of reset
  always_ff @(posedge clk) begin
    if (reset) begin
      remote_fault_latch_q <= 1'b0;
      link_up_latch_q      <= 1'b0;
      autoneg_done_q       <= 1'b0;
    end else begin
      remote_fault_latch_q <= remote_fault_latch_d;
      link_up_latch_q      <= link_up_latch_d;
      autoneg_done_q       <= autoneg_done_in;
    end
  end

  // ----------------------------------------------------------------
  // interrupt enables and output
  // ----------------------------------------------------------------
  // only the enables are writable, the mirrors ignore writes
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_irq_en_q <= 1'b0;
      link_irq_en_q  <= 1'b0;
    end else if (write_irq) begin
      fault_irq_en_q <= req.wdata[bss_pkg::BIT_IRQ_FAULT_ENABLE];
      link_irq_en_q  <= req.wdata[bss_pkg::BIT_IRQ_LINK_ENABLE];
    end
  end

  // fault mirror high or link mirror low raises the request
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (fault_irq_en_q & remote_fault_latch_q)
             | (link_irq_en_q & ~link_up_latch_q);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  // fixed abilities plus the live indicators, reserved bits zero
  always_comb begin
    basic_status = 16'h0000;
    basic_status[bss_pkg::BIT_CAP_FAST_FULL_DUPLEX]    = 1'b1;
    basic_status[bss_pkg::BIT_CAP_FAST_HALF_DUPLEX]    = 1'b1;
    basic_status[bss_pkg::BIT_CAP_TEN_FULL_DUPLEX]     = 1'b1;
    basic_status[bss_pkg::BIT_CAP_TEN_HALF_DUPLEX]     = 1'b1;
    basic_status[bss_pkg::BIT_EXTENDED_STATUS_PRESENT] = 1'b1;
    basic_status[bss_pkg::BIT_NO_PREAMBLE_CAPABLE]     = 1'b1;
    basic_status[bss_pkg::BIT_AUTONEG_DONE]   = autoneg_done_q;
    basic_status[bss_pkg::BIT_REMOTE_FAULT_LATCH] =
      remote_fault_latch_q;
    basic_status[bss_pkg::BIT_AUTONEG_CAPABLE]         = 1'b1;
    basic_status[bss_pkg::BIT_LINK_UP_LATCH] = link_up_latch_q;
    basic_status[bss_pkg::BIT_EXTENDED_REGS_PRESENT]   = 1'b1;
  end

  // read-only copies of the two latches beside their enables
  always_comb begin
    interrupt_flags = 16'h0000;
    interrupt_flags[bss_pkg::BIT_IRQ_FAULT_MIRROR] =
      remote_fault_latch_q;
    interrupt_flags[bss_pkg::BIT_IRQ_LINK_MIRROR] =
      link_up_latch_q;
    interrupt_flags[bss_pkg::BIT_IRQ_FAULT_ENABLE] = fault_irq_en_q;
    interrupt_flags[bss_pkg::BIT_IRQ_LINK_ENABLE]  = link_irq_en_q;
  end

  // read mux, unmapped addresses answer zero
  assign rd_data = sel_status  ? basic_status :
                   sel_partner ? partner_ability_q :
                   sel_irq     ? interrupt_flags :
                   16'h0000;

endmodule

// ===== verif/bss_status_assertions.sv
`timescale 1ns/1ps
module bss_status_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic rx_loss_of_signal_in,
  input wire logic cdr_loss_of_lock,
  input wire logic sgmii_mode,
  input wire logic pcs_link_up,
  input wire logic partner_word_valid,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [3:0] since_rise_q;
  logic [4:0] rises_q;
  logic [3:0] quiet_q;

  // cycles since mdc rise, mdc rises while driving, cycles since cause
  always_ff @(posedge clk) begin
    if (reset) begin
      since_rise_q <= 4'hF;
      rises_q      <= 5'h00;
      quiet_q      <= 4'hF;
    end else begin
      since_rise_q <= $rose(mdc_in) ? 4'h0 :
                      (since_rise_q == 4'hF) ? 4'hF : since_rise_q + 4'h1;
      if ($rose(mdio_oe)) rises_q <= 5'h00;
      else if ($rose(mdc_in) && mdio_oe) rises_q <= rises_q + 5'h01;
      quiet_q <= ($rose(mdc_in) || $changed(rx_loss_of_signal_in) ||
                  $changed(cdr_loss_of_lock) || $changed(sgmii_mode) ||
                  $changed(pcs_link_up) || partner_word_valid) ? 4'h0 :
                 (quiet_q == 4'hF) ? 4'hF : quiet_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_oe_reset_low: assert property ($past(reset) |-> !mdio_oe)
    else $error("pin driven right after reset");
  a_irq_reset_low: assert property ($past(reset) |-> !irq)
    else $error("irq high right after reset");
  a_oe_near_mdc: assert property (
    $changed(mdio_oe) |-> since_rise_q <= 4'h5)
    else $error("drive enable moved away from mdc rise");
  a_out_near_mdc: assert property (
    $changed(mdio_out) |-> since_rise_q <= 4'h5)
    else $error("data moved away from mdc rise");
  a_turn_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not zero");
  a_oe_holds: assert property ($rose(mdio_oe) |=> mdio_oe [*8])
    else $error("drive enable too short");
  a_data_span: assert property ($fell(mdio_oe) |-> rises_q == 5'h11)
    else $error("read data not sixteen bits");
  a_irq_cause: assert property (
    $changed(irq) |-> quiet_q <= 4'h8)
    else $error("irq moved without cause");
endmodule

bind bss_status_top bss_status_assertions chk_u (
  .clk(clk), .reset(reset), .mdc_in(mdc_in), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .rx_loss_of_signal_in(rx_loss_of_signal_in),
  .cdr_loss_of_lock(cdr_loss_of_lock), .sgmii_mode(sgmii_mode),
  .pcs_link_up(pcs_link_up), .partner_word_valid(partner_word_valid),
  .irq(irq)
);

// ===== verif/bss_station_model.sv
`timescale 1ns/1ps
module bss_station_model (
  input  wire logic clk,
  output logic      mdc_out,
  output logic      mdio_drv,
  output logic      mdio_en,
  input  wire logic mdio_wire
);
  // ----------------------------------------------------------------
  // management frame master, mdc still low between frames
  // ----------------------------------------------------------------
  initial begin
    mdc_out  = 1'h0;
    mdio_drv = 1'h0;
    mdio_en  = 1'h0;
  end

  // one frame: 32 mdc periods of 16 clk, bit set while mdc low
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ta);
    logic [31:0] bits;
    bits = {2'h1, op, phy, ra, 2'h2, wd};
    rd   = 16'h0000;
    ta   = 1'h1;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      #1;
      mdc_out  = 1'h0;
      mdio_en  = (i < 14) || (op == bss_pkg::OP_WRITE);
      mdio_drv = bits[31-i];
      repeat (8) @(posedge clk);
      #1;
      if (i == 15) ta = mdio_wire; // device answers zero here
      if (i > 15) rd = {rd[14:0], mdio_wire};
      mdc_out = 1'h1;
      repeat (7) @(posedge clk);
    end
    @(posedge clk);
    #1;
    mdc_out = 1'h0;
    mdio_en = 1'h0; // released line floats to the pull-up
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule

// ===== verif/bss_status_top_tb.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
  end \
end
module bss_status_top_tb;
  localparam logic [4:0]  PHY  = 5'h05;
  localparam logic [15:0] BASE = 16'h7949;
  localparam logic [15:0] BL   = 16'h794D;
  localparam logic [15:0] FLT  = 16'h0010;
  localparam logic [4:0]  BS   = bss_pkg::ADDR_BASIC_STATUS;
  localparam logic [4:0]  PA   = bss_pkg::ADDR_PARTNER_ABILITY;
  localparam logic [4:0]  IFL  = bss_pkg::ADDR_INTERRUPT_FLAGS;

  logic        clk;
  logic        reset;
  logic        mdc_w;
  logic        st_drv;
  logic        st_en;
  logic        mdio_out;
  logic        mdio_oe;
  logic        los;
  logic        cdr;
  logic        sgmii;
  logic        an_done;
  logic        link_up;
  logic [15:0] pw;
  logic        pw_valid;
  logic        irq;
  wire         mdio_wire;
  int          n_mismatch;
  int          cmp_count;

  // ----------------------------------------------------------------
  // clock, wire resolution, instances
  // ----------------------------------------------------------------
  initial clk = 1'h0;
  always #5 clk = ~clk;

  // pulled-up management line
  assign mdio_wire = st_en ? st_drv : (mdio_oe ? mdio_out : 1'h1);

  bss_status_top #(.PHY_ADDR(PHY)) dut_u (
    .clk(clk), .reset(reset), .mdc_in(mdc_w), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_loss_of_signal_in(los),
    .cdr_loss_of_lock(cdr), .sgmii_mode(sgmii), .autoneg_done_in(an_done),
    .pcs_link_up(link_up), .partner_word(pw),
    .partner_word_valid(pw_valid), .irq(irq)
  );

  bss_station_model st_u (
    .clk(clk), .mdc_out(mdc_w), .mdio_drv(st_drv), .mdio_en(st_en),
    .mdio_wire(mdio_wire)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rdp(input logic [4:0] phy, input logic [4:0] a,
                     input logic [15:0] e);
    logic [15:0] d;
    logic        ta;
    st_u.xfer(bss_pkg::OP_READ, phy, a, 16'h0000, d, ta);
    `CHECK(d, e)
    `CHECK(ta, (phy != PHY))
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    rdp(PHY, a, e);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] wd);
    logic [15:0] d;
    logic        ta;
    st_u.xfer(bss_pkg::OP_WRITE, PHY, a, wd, d, ta);
  endtask

  task automatic load(input logic [15:0] w);
    pw       = w;
    pw_valid = 1'h1;
    tick(1);
    pw_valid = 1'h0;
    tick(1);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    cmp_count  = 0;
    reset = 1'h1;
    {los, cdr, sgmii, an_done, link_up, pw_valid} = 6'h00;
    pw = 16'h0000;
    tick(20);
    reset = 1'h0;
    tick(4);
    rdc(BS, BASE);
    `CHECK(irq, 1'h0)
    an_done = 1'h1;
    rdc(BS, BASE | 16'h0020);
    an_done = 1'h0;
    rdc(BS, BASE);
    link_up = 1'h1;
    rdc(BS, BASE);
    rdc(BS, BL);
    link_up = 1'h0;
    tick(2);
    link_up = 1'h1;
    rdc(BS, BASE);
    rdc(BS, BL);
    // serial gigabit fault sources
    sgmii = 1'h1;
    los   = 1'h1;
    tick(3);
    los = 1'h0;
    rdc(BS, BL | FLT);
    rdc(BS, BL);
    cdr = 1'h1;
    rdc(BS, BL | FLT);
    rdc(BS, BL | FLT);
    cdr = 1'h0;
    rdc(BS, BL | FLT);
    rdc(BS, BL);
    // fibre mode: every nonzero partner fault code
    sgmii = 1'h0;
    for (int c = 1; c < 4; c++) begin
      load({2'h0, 2'(c), 12'h0A5});
      rdc(PA, {2'h0, 2'(c), 12'h0A5});
      load(16'h0000);
      rdc(BS, BL | FLT);
      rdc(BS, BL);
    end
    wr(BS, 16'h86B2);
    rdc(BS, BL);
    wr(PA, 16'hFFFF);
    rdc(PA, 16'h0000);
    rdc(5'h07, 16'h0000);
    rdp(PHY ^ 5'h01, BS, 16'hFFFF);
    // link mirror interrupt
    wr(IFL, 16'h0400);
    tick(8);
    `CHECK(irq, 1'h0)
    rdc(IFL, 16'h0404);
    link_up = 1'h0;
    tick(8);
    `CHECK(irq, 1'h1)
    rdc(IFL, 16'h0400);
    link_up = 1'h1;
    rdc(BS, BASE);
    tick(8);
    `CHECK(irq, 1'h0)
    // fault mirror interrupt
    wr(IFL, 16'h1000);
    sgmii = 1'h1;
    los   = 1'h1;
    tick(8);
    `CHECK(irq, 1'h1)
    los = 1'h0;
    rdc(IFL, 16'h1014);
    rdc(BS, BL | FLT);
    tick(8);
    `CHECK(irq, 1'h0)
    // second reset in mid-run: word, fault, irq raised, link up held
    load(16'h0A5A);
    los = 1'h1;
    tick(8);
    `CHECK(irq, 1'h1)
    los   = 1'h0;
    reset = 1'h1;
    tick(2);
    reset = 1'h0;
    tick(4);
    `CHECK(irq, 1'h0)
    rdc(PA, 16'h0000);
    rdc(BS, BASE);
    rdc(IFL, 16'h0004);
    wrap_up();
  end

  // hang guard, well past the expected run length
  initial begin
    #500000;
    n_mismatch++;
    wrap_up();
  end
endmodule
